// [flash_ctl_pkg.sv]
// Constants for the flash wake, hold and soft-reset control block
// Behaviour
// - Opcode 79h enters ultra sleep; ignores commands
// - Dummy byte during wake pulse is ignored
// - Pulse release reaches standby within exit time
// - Reselect before exit time discards the operation
// - Early first bit wakes but drops command
// - Waking restores all registers to defaults
// - Pause never stops program or erase
// - Pause starts on hold in clock low
// - Hold in high phase pauses next low
// - Pause lasts while hold and select active
// - Paused: output floats, input and clock ignored
// - Pause ends at low phase after release
// - Deselect while held aborts, clears write enable
// - Soft reset aborts busy work, ignores write enable
// - Soft reset acts only when enable bit set
// - Reset is F0h then D0h, rest ignored
// - Deselect after reset stops work within stop time
// - Reset keeps config and enable, clears latch unless sequential programming
// - Reset needs complete bytes and byte-aligned deselect
package flash_ctl_pkg;
    // ---------------------------------------------------------------
    // Opcodes
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_ULTRA_SLEEP = 8'h79;
    localparam logic [7:0] OP_SOFT_RESET  = 8'hF0;
    localparam logic [7:0] OP_RESET_CONF  = 8'hD0;
    localparam logic [7:0] OP_STATUS2_WR  = 8'h31;
    localparam logic [7:0] OP_WRITE_EN    = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS   = 8'h04;
    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int         RESET_ENABLE_BIT_POS       = 4;
    localparam logic       WEL_RESET      = 1'b0;
    localparam logic       RESET_ENABLE_BIT_RESET     = 1'b0;
    // ---------------------------------------------------------------
    // Timing, 25 MHz clock
    // ---------------------------------------------------------------
    localparam int         CLK_MHZ        = 25;
    localparam int         WAKE_PULSE_NS  = 200;
    localparam int         EXIT_NS        = 800;
    localparam int         STOP_NS        = 400;
    localparam int         WAKE_PULSE_CYC = (WAKE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int         EXIT_CYC       = (EXIT_NS * CLK_MHZ) / 1000;
    localparam int         STOP_CYC       = (STOP_NS * CLK_MHZ) / 1000;
    localparam int         CNT_W          = 16;
endpackage

// [flash_wake_hold_soft_reset.sv]
// Wake, hold and soft-reset control logic of the serial flash
`timescale 1ns/1ns
module flash_wake_hold_soft_reset #(
    parameter int WAKE_CYC = flash_ctl_pkg::WAKE_PULSE_CYC,
    parameter int EXIT_CYC = flash_ctl_pkg::EXIT_CYC,
    parameter int STOP_CYC = flash_ctl_pkg::STOP_CYC
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       cs_n,           // Chip select pin
    input  wire logic       sck,            // Serial clock pin
    input  wire logic       si,             // Serial data in pin
    input  wire logic       hold_n,         // Hold pin
    input  wire logic       wp_n,           // Write-protect pin
    input  wire logic       busy_in,        // Program or erase engine running
    input  wire logic       seq_prog,       // Sequential programming active
    input  wire logic       so_data,        // Data bit from read path
    output logic            so_out,         // Serial output level
    output logic            so_oe,          // Serial output enable
    output logic            wp_active,      // Write protect seen, works in pause
    output logic            ultra_sleep,    // Lowest power state
    output logic            paused,         // Hold state
    output logic            abort_op,       // Pulse: stop engine
    output logic            write_enable_latch,
    output logic            reset_enable_bit,
    output logic [7:0]      cmd_byte,       // Last full byte taken
    output logic            cmd_valid       // Pulse: byte for other decoders
);
    // -------------------------------------------------------------------
    // Input synchronisers
    // -------------------------------------------------------------------
    logic [3:0] s1_reg;                     // First stage
    logic [3:0] s2_reg;                     // Second stage
    logic [3:0] s3_reg;                     // Previous sample for edges
    logic       wp1_reg;
    logic       wp2_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg  <= 4'hF;
            s2_reg  <= 4'hF;
            s3_reg  <= 4'hF;
            wp1_reg <= 1'b1;
            wp2_reg <= 1'b1;
        end else begin
            s1_reg  <= {cs_n, sck, si, hold_n};
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            wp1_reg <= wp_n;
            wp2_reg <= wp1_reg;
        end
    end
    wire cs_act = !s2_reg[3];
    wire sck_s  = s2_reg[2];
    wire si_s   = s2_reg[1];
    wire hold_a = !s2_reg[0];
    wire sck_rise = sck_s && !s3_reg[2];
    wire cs_rise  = s2_reg[3] && !s3_reg[3];
    wire cs_fall  = !s2_reg[3] && s3_reg[3];
    assign wp_active = !wp2_reg;

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_SLEEP, ST_EXIT} pwr_t;
    typedef enum logic [1:0] {RS_OP, RS_CONF, RS_ARMED, RS_NONE} rst_t;
    pwr_t        pwr_reg, pwr_next;
    rst_t        rs_reg, rs_next;
    logic [2:0]  bit_reg, bit_next;         // Bits in current byte
    logic [7:0]  sh_reg, sh_next;           // Shift register
    logic        first_reg, first_next;     // First byte of frame
    logic        drop_reg, drop_next;       // Frame discarded
    logic        hold_reg, hold_next;
    logic        wel_reg, wel_next;
    logic        reset_enable_bit_reg, reset_enable_bit_next;
    logic        st2_reg, st2_next;         // Status-2 write pending
    logic        abort_reg, abort_next;
    logic        val_reg, val_next;
    logic [7:0]  cmd_reg, cmd_next;
    logic        so_reg, so_next;
    logic [flash_ctl_pkg::CNT_W-1:0] cnt_reg, cnt_next;

    // -------------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------------
    always_comb begin
        logic [7:0] byte_v;
        byte_v     = {sh_reg[6:0], si_s};
        pwr_next   = pwr_reg;
        rs_next    = rs_reg;
        bit_next   = bit_reg;
        sh_next    = sh_reg;
        first_next = first_reg;
        drop_next  = drop_reg;
        hold_next  = hold_reg;
        wel_next   = wel_reg;
        reset_enable_bit_next  = reset_enable_bit_reg;
        st2_next   = st2_reg;
        abort_next = 1'b0;
        val_next   = 1'b0;
        cmd_next   = cmd_reg;
        so_next    = so_reg;
        cnt_next   = cnt_reg;
        // Hold changes only while clock low or on deselect; high phase defers
        if (!cs_act) begin
            hold_next = 1'b0;
        end else if (!sck_s) begin
            hold_next = hold_a;
        end
        // Counter runs in every state; meaning follows state
        if (cnt_reg != '1) begin
            cnt_next = cnt_reg + 1'b1;
        end
        case (pwr_reg)
            ST_SLEEP: begin
                // Ignore everything; only select timing wakes
                // Frame start in sleep: time from here, bits from zero
                if (cs_fall) begin
                    cnt_next   = '0;
                    bit_next   = '0;
                    first_next = 1'b1;
                end
                if (cs_act && sck_rise && cnt_reg >= EXIT_CYC[flash_ctl_pkg::CNT_W-1:0]) begin
                    pwr_next  = ST_IDLE;    // Select-low wake, bit legal
                    drop_next = 1'b0;
                    sh_next   = byte_v;     // Waking bit is the opcode's first bit
                    bit_next  = 3'd1;
                end else if (cs_act && sck_rise) begin
                    pwr_next  = ST_IDLE;
                    drop_next = 1'b1;
                end else if (cs_rise && cnt_reg >= WAKE_CYC[flash_ctl_pkg::CNT_W-1:0]) begin
                    pwr_next = ST_EXIT;
                    cnt_next = '0;
                end
                if (pwr_next != ST_SLEEP) begin
                    wel_next  = flash_ctl_pkg::WEL_RESET;
                    reset_enable_bit_next = flash_ctl_pkg::RESET_ENABLE_BIT_RESET;
                    rs_next   = RS_OP;
                end
            end
            ST_EXIT: begin
                if (cs_fall) begin
                    drop_next = 1'b1;
                end
                if (cnt_reg >= EXIT_CYC[flash_ctl_pkg::CNT_W-1:0]) begin
                    pwr_next = ST_IDLE;
                end
            end
            default: begin
                if (cs_fall) begin
                    bit_next   = '0;
                    first_next = 1'b1;
                    rs_next    = RS_OP;
                end
                // Shift only when not paused
                if (cs_act && !hold_reg && sck_rise) begin
                    sh_next  = byte_v;
                    bit_next = bit_reg + 3'd1;
                    if (bit_reg == 3'd7 && !drop_reg) begin
                        first_next = 1'b0;
                        val_next   = 1'b1;
                        cmd_next   = byte_v;
                        if (st2_reg) begin
                            reset_enable_bit_next = byte_v[flash_ctl_pkg::RESET_ENABLE_BIT_POS];
                            st2_next  = 1'b0;
                        end
                        case (rs_reg)
                            RS_OP:   rs_next = (first_reg && byte_v == flash_ctl_pkg::OP_SOFT_RESET)
                                               ? RS_CONF : RS_NONE;
                            RS_CONF: rs_next = (byte_v == flash_ctl_pkg::OP_RESET_CONF)
                                               ? RS_ARMED : RS_NONE;
                            default: rs_next = rs_reg;
                        endcase
                        if (first_reg) begin
                            st2_next = (byte_v == flash_ctl_pkg::OP_STATUS2_WR);
                        end
                    end
                end
                if (cs_rise) begin
                    drop_next = 1'b0;
                    st2_next  = 1'b0;
                    if (hold_reg) begin
                        abort_next = 1'b1;
                        wel_next   = 1'b0;
                    end else if (!drop_reg && bit_reg == 3'd0 && !first_reg) begin
                        if (cmd_reg == flash_ctl_pkg::OP_ULTRA_SLEEP && rs_reg == RS_NONE
                            && !busy_in) begin
                            pwr_next = ST_SLEEP;
                            cnt_next = '0;
                        end else if (cmd_reg == flash_ctl_pkg::OP_WRITE_EN) begin
                            wel_next = 1'b1;
                        end else if (cmd_reg == flash_ctl_pkg::OP_WRITE_DIS) begin
                            wel_next = 1'b0;
                        end
                        // Byte-aligned, armed, enabled; latch not consulted
                        if (rs_reg == RS_ARMED && reset_enable_bit_reg) begin
                            abort_next = 1'b1;
                            if (!seq_prog) begin
                                wel_next = flash_ctl_pkg::WEL_RESET;
                            end
                        end
                    end
                end
            end
        endcase
        // Output floats while paused, deselected or asleep
        if (!sck_s) begin
            so_next = so_data;
        end
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_reg   <= ST_IDLE;
            rs_reg    <= RS_OP;
            bit_reg   <= '0;
            sh_reg    <= '0;
            first_reg <= 1'b1;
            drop_reg  <= 1'b0;
            hold_reg  <= 1'b0;
            wel_reg   <= flash_ctl_pkg::WEL_RESET;
            reset_enable_bit_reg  <= flash_ctl_pkg::RESET_ENABLE_BIT_RESET;
            st2_reg   <= 1'b0;
            abort_reg <= 1'b0;
            val_reg   <= 1'b0;
            cmd_reg   <= '0;
            so_reg    <= 1'b0;
            cnt_reg   <= '0;
        end else begin
            pwr_reg   <= pwr_next;
            rs_reg    <= rs_next;
            bit_reg   <= bit_next;
            sh_reg    <= sh_next;
            first_reg <= first_next;
            drop_reg  <= drop_next;
            hold_reg  <= hold_next;
            wel_reg   <= wel_next;
            reset_enable_bit_reg  <= reset_enable_bit_next;
            st2_reg   <= st2_next;
            abort_reg <= abort_next;
            val_reg   <= val_next;
            cmd_reg   <= cmd_next;
            so_reg    <= so_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Engine keeps running under hold; no pause reaches busy path
    assign so_out             = so_reg;
    assign so_oe              = cs_act && !hold_reg && pwr_reg == ST_IDLE;
    assign ultra_sleep        = pwr_reg == ST_SLEEP;
    assign paused             = hold_reg;
    assign abort_op           = abort_reg;
    assign write_enable_latch = wel_reg;
    assign reset_enable_bit   = reset_enable_bit_reg;
    assign cmd_byte           = cmd_reg;
    assign cmd_valid          = val_reg;

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    // Pause: output off, entry only in a low phase and only while selected
    a_hold_float: assert property (@(posedge clk) disable iff (!nrst)
        hold_reg |-> !so_oe) else $error("Output driven in pause");
    a_hold_low_only: assert property (@(posedge clk) disable iff (!nrst)
        $rose(hold_reg) |-> $past(!sck_s)) else $error("Pause began in high phase");
    a_hold_needs_cs: assert property (@(posedge clk) disable iff (!nrst)
        hold_reg |-> $past(cs_act)) else $error("Pause without select");
    a_hold_abort: assert property (@(posedge clk) disable iff (!nrst)
        (cs_rise && hold_reg && pwr_reg == ST_IDLE) |=> (abort_reg && !wel_reg))
        else $error("Held deselect did not abort");
    // Soft reset: gated by the enable bit and by the full two-byte sequence
    a_rst_gate: assert property (@(posedge clk) disable iff (!nrst)
        (cs_rise && pwr_reg == ST_IDLE && !reset_enable_bit_reg && !hold_reg) |=> !abort_reg)
        else $error("Reset acted while disabled");
    a_rst_seq: assert property (@(posedge clk) disable iff (!nrst)
        (cs_rise && !hold_reg && pwr_reg == ST_IDLE && rs_reg != RS_ARMED) |=> !abort_reg)
        else $error("Abort without full reset sequence");
    a_rst_keep_en: assert property (@(posedge clk) disable iff (!nrst)
        abort_reg |-> $stable(reset_enable_bit_reg)) else $error("Reset changed enable bit");
    // Step one: a clean, armed, enabled deselect on a byte boundary
    sequence s_rst_release;
        cs_rise && !hold_reg && pwr_reg == ST_IDLE && rs_reg == RS_ARMED && reset_enable_bit_reg
            && !drop_reg && bit_reg == 3'd0 && !first_reg;
    endsequence
    // Step two: the engine is told to stop
    sequence s_engine_stop;
        abort_reg;
    endsequence
    a_rst_stop: assert property (@(posedge clk) disable iff (!nrst)
        s_rst_release |-> ##[1:STOP_CYC] s_engine_stop)
        else $error("Reset did not stop work");
    // Ultra sleep: quiet while asleep, defaults and bounded exit on wake
    a_sleep_wake: assert property (@(posedge clk) disable iff (!nrst)
        (pwr_reg == ST_EXIT && cnt_reg >= EXIT_CYC[flash_ctl_pkg::CNT_W-1:0])
        |=> pwr_reg == ST_IDLE) else $error("Exit time overrun");
    a_sleep_defaults: assert property (@(posedge clk) disable iff (!nrst)
        (pwr_reg == ST_SLEEP && pwr_next != ST_SLEEP) |=> (!wel_reg && !reset_enable_bit_reg))
        else $error("Registers not default on wake");
    a_sleep_quiet: assert property (@(posedge clk) disable iff (!nrst)
        pwr_reg == ST_SLEEP |-> (!val_reg && !abort_reg)) else $error("Command in sleep");
    // A first bit before the exit time wakes the part but loses the frame
    sequence s_early_bit;
        pwr_reg == ST_SLEEP && cs_act && sck_rise
            && cnt_reg < EXIT_CYC[flash_ctl_pkg::CNT_W-1:0];
    endsequence
    a_wake_early: assert property (@(posedge clk) disable iff (!nrst)
        s_early_bit |=> (pwr_reg == ST_IDLE && drop_reg))
        else $error("Early bit not dropped");
endmodule

// [spi_host_model.sv]
// Host-side model driving the flash select, clock, data and hold pins
`timescale 1ns/1ns
module spi_host_model (
    input  wire logic clk,
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      hold_n
);
    // ----------------------------------------------------------------
    // Pin state and expected byte notes
    // ----------------------------------------------------------------
    logic [7:0] exp_q[$];  // Bytes the flash should report, oldest first
    logic       quiet;     // Set when the flash is meant to drop the bytes
    // Idle pins: deselected, clock parked low, hold released
    initial begin
        cs_n   = 1'b1;
        sck    = 1'b0;
        si     = 1'b0;
        hold_n = 1'b1;
        quiet  = 1'b0;
    end
    // Data line is undriven while deselected, so it wanders every cycle
    always @(posedge clk) begin
        if (cs_n)
            si <= ~si;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Data set up half a period before the rising clock edge
    task automatic rise(input logic v);
        si <= v;
        tick(4);
        sck <= ~sck;    // Parked low by fall, so this is the rising edge
        tick(4);
    endtask
    task automatic fall();
        sck <= 1'b0;
    endtask
    task automatic set_hold(input logic v);
        hold_n <= v;
        tick(2);
    endtask
    // MSB first; only whole bytes are noted as expected
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            rise(b[i]);
            fall();
        end
        if (n == 8 && !quiet)
            exp_q.push_back(b);
    endtask
    task automatic select();
        cs_n <= ~cs_n;  // Always entered deselected, so this selects
        tick(4);
    endtask
    // Ten idle cycles keep the select high time well over the minimum
    task automatic deselect();
        tick(4);
        cs_n <= 1'b1;
        tick(10);
    endtask
    // Frame of nb bytes from the top of b, then tail stray bits
    task automatic frame(input logic [23:0] b, input int nb, input int tail);
        select();
        for (int k = 0; k < nb; k++)
            send(b[23 - 8 * k -: 8], 8);
        if (tail > 0)
            send(8'hA5, tail);
        deselect();
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the flash wake, hold and soft-reset block
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------------------------------
    // Signals, counters and instances
    // ----------------------------------------------------------------
    logic       clk, nrst, wp_n, busy_in, seq_prog, so_data;
    logic       so_out, so_oe, wp_active, ultra_sleep, paused, abort_op;
    logic       write_enable_latch, reset_enable_bit, cmd_valid;
    logic [7:0] cmd_byte;
    logic [7:0] b;          // Byte under test
    logic       cs_n, sck, si, hold_n;
    logic       keep;       // Random level under test
    logic       so_prev;    // Read-path bit as the output flop took it
    int         errors = 0;
    int         samples_checked = 0;
    int         abort_cnt = 0;  // Abort pulses seen so far
    int         a0 = 0;         // Abort count at the last check
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
    flash_wake_hold_soft_reset dut (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck),
        .si(si), .hold_n(hold_n), .wp_n(wp_n), .busy_in(busy_in), .seq_prog(seq_prog),
        .so_data(so_data), .so_out(so_out), .so_oe(so_oe), .wp_active(wp_active),
        .ultra_sleep(ultra_sleep), .paused(paused), .abort_op(abort_op),
        .write_enable_latch(write_enable_latch), .reset_enable_bit(reset_enable_bit),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Flags packed as {sleep, paused, write latch, reset enable}
    task automatic flags(input logic [3:0] exp);
        check("flags", {4'h0, ultra_sleep, paused, write_enable_latch, reset_enable_bit},
              {4'h0, exp});
    endtask
    // Aborts since the last call; checked a stop time after deselect
    task automatic aborts(input int n);
        check("aborts", 8'(abort_cnt - a0), 8'(n));
        a0 = abort_cnt;
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Read path bit is random noise; its enable and one so_out sample are judged
    always @(posedge clk) begin
        so_prev <= so_data;
        so_data <= 1'($urandom);
    end
    // Monitor: every byte pulse takes the oldest note, abort pulses are counted
    always @(posedge clk) begin
        if (abort_op === 1'b1)
            abort_cnt <= abort_cnt + 1;
        if (cmd_valid === 1'b1 && host.exp_q.size() == 0) begin
            errors++;
            samples_checked++;
            $display("Error cmd_byte expected none seen %h", cmd_byte);
        end else if (cmd_valid === 1'b1) begin
            check("cmd_byte", cmd_byte, host.exp_q.pop_front());
        end
    end
    // Watchdog after 50000 cycles; the sequence needs well under 20000
    initial begin
        #2000000;
        errors++;
        stop_test();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(74));
        {nrst, busy_in, seq_prog} = 3'h0;
        wp_n = 1'b1;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        host.tick(4);
        flags(4'b0000);
        check("so_out", {7'h00, so_out}, {7'h00, so_prev});
        b = {2'b10, 6'($urandom)};
        host.frame({b, 16'h0000}, 1, 0);
        host.frame({8'h06, 16'h0000}, 1, 0);
        busy_in <= 1'($urandom);
        host.frame(24'hF0_D000, 2, 0);
        aborts(0);
        flags(4'b0010);
        host.frame(24'h31_1000, 2, 0);
        flags(4'b0011);
        host.frame(24'hF0_D055, 3, 0);
        aborts(1);
        flags(4'b0001);
        host.frame(24'hF0_D000, 2, 0);
        aborts(1);
        host.frame({8'h06, 16'h0000}, 1, 0);
        host.frame(24'hF0_D000, 2, 3);
        aborts(0);
        host.frame(24'hF0_0000, 1, 0);
        aborts(0);
        host.frame(24'hD0_F000, 2, 0);
        aborts(0);
        keep = 1'($urandom);
        seq_prog <= keep;
        host.frame(24'hF0_D000, 2, 0);
        aborts(1);
        flags({2'b00, keep, 1'b1});
        seq_prog <= 1'b0;
        host.frame({8'h06, 16'h0000}, 1, 0);
        // Hold raised in the clock high phase, in mid-byte
        b = {2'b10, 6'($urandom)};
        host.select();
        for (int i = 7; i >= 4; i--) begin
            host.rise(b[i]);
            host.fall();
        end
        check("so_oe", {7'h00, so_oe}, 8'h01);
        host.rise(b[3]);
        host.set_hold(1'b0);
        flags(4'b0011);
        host.fall();
        host.tick(8);
        flags(4'b0111);
        host.rise(~b[2]);
        host.fall();
        keep = 1'($urandom);
        for (int i = 0; i < 2; i++) begin
            wp_n <= keep ^ i[0];
            host.tick(6);
            check("paused pins", {6'h00, so_oe, wp_active}, {7'h00, ~(keep ^ i[0])});
        end
        flags(4'b0111);
        wp_n <= 1'b1;
        host.set_hold(1'b1);
        host.tick(6);
        flags(4'b0011);
        host.exp_q.push_back(b);
        for (int i = 2; i >= 0; i--) begin
            host.rise(b[i]);
            host.fall();
        end
        host.deselect();
        // Hold raised in the low phase, then deselect while still held
        host.select();
        host.rise(1'b0);
        host.fall();
        host.tick(2);
        host.set_hold(1'b0);
        host.tick(6);
        flags(4'b0111);
        host.deselect();
        aborts(1);
        flags(4'b0001);
        host.set_hold(1'b1);
        // Sleep entry, pulse wake, early reselect and both select-low wakes
        busy_in <= 1'b1;
        host.frame({8'h79, 16'h0000}, 1, 0);
        flags(4'b0001);
        busy_in <= 1'b0;
        host.frame({8'h79, 16'h0000}, 1, 0);
        flags(4'b1001);
        host.frame(24'h00_0000, 0, 0);
        flags(4'b0000);
        host.quiet = 1'b1;
        host.frame({8'h06, 16'h0000}, 1, 0);
        flags(4'b0000);
        host.quiet = 1'b0;
        host.tick(flash_ctl_pkg::EXIT_CYC);
        host.frame({8'h06, 16'h0000}, 1, 0);
        flags(4'b0010);
        host.frame({8'h79, 16'h0000}, 1, 0);
        flags(4'b1010);
        host.select();
        host.tick(flash_ctl_pkg::EXIT_CYC + 4);
        host.send(8'h06, 8);
        host.deselect();
        flags(4'b0010);
        host.frame({8'h79, 16'h0000}, 1, 0);
        host.quiet = 1'b1;
        host.frame({8'h06, 16'h0000}, 1, 0);
        host.quiet = 1'b0;
        flags(4'b0000);
        check("pending", 8'(host.exp_q.size()), 8'h00);
        stop_test();
    end
endmodule
